// ---- core/imd_cfg.svh ----
`ifndef IMD_CFG_SVH
`define IMD_CFG_SVH
`define IMD_ADDR_W 32
`define IMD_DATA_W 32
`define IMD_SYSTEM_PIN_CONTROL10_ADDR 32'hffffff78
`define IMD_SERIAL_PORT2_PIN_CONTROL9_ADDR 32'hfff7f668
`define IMD_PMX_BASE 32'hffffea00
`define IMD_PMX_COUNT 35
`define IMD_PMX_RESET 32'h00000000
`define IMD_SYSTEM_PIN_CONTROL10_RESET 32'h00000000
`define IMD_SERIAL_PORT2_PIN_CONTROL9_RESET 32'h00000000
`define IMD_EXTERNAL_CLOCK_OUTPUT_DRV_BIT 0
`define IMD_SERIAL_PORT2_CLOCK_PIN_DRV_BIT 9
`define IMD_SERIAL_PORT2_DATA_OUT_PIN_DRV_BIT 10
`define IMD_SERIAL_PORT2_DATA_IN_PIN_DRV_BIT 11
`define IMD_SERIAL_PORT2_DATA_IN_PIN_ALT_BIT 24
`define IMD_GPB2_SEL_REG 29
`define IMD_GPB2_SEL_BIT 16
`define IMD_TMR_CH 8
`define IMD_TMR_B1_REG '{20, 8, 9, 12, 7, 0, 0, 9}
`define IMD_TMR_B1_BIT '{17, 9, 25, 17, 9, 26, 18, 10}
`define IMD_TMR_B2_REG '{24, 24, 25, 25, 25, 25, 26, 26}
`define IMD_TMR_B2_BIT '{16, 24, 0, 8, 16, 24, 0, 8}
`endif

// ---- core/imd_pkg.sv ----
package imd_pkg;
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} imd_bus_req_t;
	typedef struct packed {
		logic external_clock_output;
		logic spi2_clk;
		logic spi2_simo;
		logic spi2_somi;
	} imd_drive_t;
	typedef struct packed {
		logic pull_disable;
		logic pull_select;
	} imd_pull_t;
endpackage

// ---- core/imd_input_mux.sv ----
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`include "imd_cfg.svh"
// Notes on behaviour
// - a timer input takes its alternate terminal only when its first select bit is 1 and its second is 0.
// - general-purpose port b bit 2 takes its alternate terminal when its select bit is 1, else the dedicated one.
// - while that alternate path is selected, pull disable is held at 0 and pull select at 1.
// - after reset every multiplexed input comes from its dedicated terminal.
// - control bits for the fourth serial port stay readable and writable though they steer nothing.
// - clock output and serial port 2 clock, data-out and data-in drive 8mA on a 0 bit and 2mA on a 1.
// - either of two bits in the serial port 2 pin control register can set data-in drive strength.
// - when one write gives those two bits different values, bit 11 decides.
// - a control reference x[y] means bit y of multiplexing control register x.
module imd_input_mux #(
	parameter int TMR_CH = `IMD_TMR_CH
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire imd_pkg::imd_bus_req_t bus_req,
	output logic [31:0] rdata,
	input wire logic [TMR_CH-1:0] timer_ded_in,
	input wire logic [TMR_CH-1:0] timer_alt_in,
	output logic [TMR_CH-1:0] timer_channel_input,
	input wire logic gp_port_b_second_select_bit_ded,
	input wire logic gp_port_b_second_select_bit_alt,
	output logic gp_port_b_second_select_bit,
	input wire imd_pkg::imd_pull_t gp_b2_pull_req,
	output imd_pkg::imd_pull_t gp_b2_pull,
	output imd_pkg::imd_drive_t drive_low
);
	import imd_pkg::*;

	localparam int B1_REG[8] = `IMD_TMR_B1_REG;
	localparam int B1_BIT[8] = `IMD_TMR_B1_BIT;
	localparam int B2_REG[8] = `IMD_TMR_B2_REG;
	localparam int B2_BIT[8] = `IMD_TMR_B2_BIT;

	// select tables are fixed at eight channels
	if (TMR_CH != `IMD_TMR_CH) begin : g_bad_tmr_ch
		$error("imd_input_mux: timer channel count must match the select table");
	end

	// ****************************************
	// register file
	// ****************************************
	logic [31:0] pmx_ff [`IMD_PMX_COUNT];
	logic [31:0] nxt_pmx [`IMD_PMX_COUNT];
	logic [31:0] system_pin_control10_ff;
	logic [31:0] nxt_system_pin_control10;
	logic [31:0] serial_port2_pin_control9_ff;
	logic [31:0] nxt_serial_port2_pin_control9;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [31:0] pmx_off;
	logic pmx_hit;
	logic [5:0] pmx_idx;

	always_comb begin
		pmx_off = bus_req.addr - `IMD_PMX_BASE;
		pmx_hit = (pmx_off < 32'(`IMD_PMX_COUNT * 4)) && (pmx_off[1:0] == 2'h0);
		pmx_idx = pmx_off[7:2];
	end

	always_comb begin
		nxt_pmx = pmx_ff;
		nxt_system_pin_control10 = system_pin_control10_ff;
		nxt_serial_port2_pin_control9 = serial_port2_pin_control9_ff;
		nxt_rdata = 32'h00000000;
		if (bus_req.wr) begin
			// every bit kept, including unused serial port 4 controls, except a serial port 2 bit 24 that differs from bit 11
			if (pmx_hit)
				nxt_pmx[pmx_idx] = bus_req.wdata;
			if (bus_req.addr == `IMD_SYSTEM_PIN_CONTROL10_ADDR)
				nxt_system_pin_control10 = bus_req.wdata;
			if (bus_req.addr == `IMD_SERIAL_PORT2_PIN_CONTROL9_ADDR) begin
				nxt_serial_port2_pin_control9 = bus_req.wdata;
				// mismatched pair: both copies follow bit 11
				if (bus_req.wdata[`IMD_SERIAL_PORT2_DATA_IN_PIN_DRV_BIT] != bus_req.wdata[`IMD_SERIAL_PORT2_DATA_IN_PIN_ALT_BIT])
					nxt_serial_port2_pin_control9[`IMD_SERIAL_PORT2_DATA_IN_PIN_ALT_BIT] = bus_req.wdata[`IMD_SERIAL_PORT2_DATA_IN_PIN_DRV_BIT];
			end
		end
		if (bus_req.rd) begin
			if (pmx_hit)
				nxt_rdata = pmx_ff[pmx_idx];
			else if (bus_req.addr == `IMD_SYSTEM_PIN_CONTROL10_ADDR)
				nxt_rdata = system_pin_control10_ff;
			else if (bus_req.addr == `IMD_SERIAL_PORT2_PIN_CONTROL9_ADDR)
				nxt_rdata = serial_port2_pin_control9_ff;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < `IMD_PMX_COUNT; i++)
				pmx_ff[i] <= `IMD_PMX_RESET;
			system_pin_control10_ff <= `IMD_SYSTEM_PIN_CONTROL10_RESET;
			serial_port2_pin_control9_ff <= `IMD_SERIAL_PORT2_PIN_CONTROL9_RESET;
			rdata_ff <= 32'h00000000;
		end else begin
			pmx_ff <= nxt_pmx;
			system_pin_control10_ff <= nxt_system_pin_control10;
			serial_port2_pin_control9_ff <= nxt_serial_port2_pin_control9;
			rdata_ff <= nxt_rdata;
		end
	end

	assign rdata = rdata_ff;

	// ****************************************
	// input selection
	// ****************************************
	logic [TMR_CH-1:0] tmr_sel;

	always_comb begin
		for (int c = 0; c < TMR_CH; c++) begin
			tmr_sel[c] = pmx_ff[B1_REG[c]][B1_BIT[c]] & ~pmx_ff[B2_REG[c]][B2_BIT[c]];
			timer_channel_input[c] = tmr_sel[c] ? timer_alt_in[c] : timer_ded_in[c];
		end
	end

	logic gpb2_sel;

	always_comb begin
		gpb2_sel = pmx_ff[`IMD_GPB2_SEL_REG][`IMD_GPB2_SEL_BIT];
		gp_port_b_second_select_bit = gpb2_sel ? gp_port_b_second_select_bit_alt : gp_port_b_second_select_bit_ded;
	end

	// ****************************************
	// pull and drive controls
	// ****************************************
	imd_pull_t pull_ff;
	imd_pull_t nxt_pull;
	imd_drive_t drive_ff;
	imd_drive_t nxt_drive;

	always_comb begin
		// computed from next select so the forced pull tracks the write
		if (nxt_pmx[`IMD_GPB2_SEL_REG][`IMD_GPB2_SEL_BIT]) begin
			nxt_pull.pull_disable = 1'b0;
			nxt_pull.pull_select = 1'b1;
		end else begin
			nxt_pull = gp_b2_pull_req;
		end
		nxt_drive.external_clock_output = nxt_system_pin_control10[`IMD_EXTERNAL_CLOCK_OUTPUT_DRV_BIT];
		nxt_drive.spi2_clk = nxt_serial_port2_pin_control9[`IMD_SERIAL_PORT2_CLOCK_PIN_DRV_BIT];
		nxt_drive.spi2_simo = nxt_serial_port2_pin_control9[`IMD_SERIAL_PORT2_DATA_OUT_PIN_DRV_BIT];
		nxt_drive.spi2_somi = nxt_serial_port2_pin_control9[`IMD_SERIAL_PORT2_DATA_IN_PIN_DRV_BIT];
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pull_ff <= '0;
			drive_ff <= '0;
		end else begin
			pull_ff <= nxt_pull;
			drive_ff <= nxt_drive;
		end
	end

	assign gp_b2_pull = pull_ff;
	assign drive_low = drive_ff;
endmodule

// ---- tb/imd_props.sv ----
`timescale 1ns/100ps
`include "imd_cfg.svh"
// ****
// port checks
// ****
module imd_props #(parameter int TMR_CH = 8) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire imd_pkg::imd_bus_req_t bus_req,
	input wire logic [31:0] rdata,
	input wire logic [TMR_CH-1:0] timer_ded_in,
	input wire logic [TMR_CH-1:0] timer_channel_input,
	input wire logic gp_port_b_second_select_bit_ded,
	input wire logic gp_port_b_second_select_bit_alt,
	input wire logic gp_port_b_second_select_bit,
	input wire imd_pkg::imd_pull_t gp_b2_pull,
	input wire imd_pkg::imd_drive_t drive_low
);
	import imd_pkg::*;
	logic ws, wp, wg;
	assign ws = bus_req.wr && bus_req.addr == `IMD_SYSTEM_PIN_CONTROL10_ADDR;
	assign wp = bus_req.wr && bus_req.addr == `IMD_SERIAL_PORT2_PIN_CONTROL9_ADDR;
	assign wg = bus_req.wr && bus_req.addr == `IMD_PMX_BASE + 32'h74;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	external_clock_output_drive_a: assert property (ws |=> drive_low.external_clock_output == $past(bus_req.wdata[0]))
		else $error("external_clock_output drive wrong");
	spi_drive_a: assert property (wp |=> {drive_low.spi2_clk, drive_low.spi2_simo} ==
		$past({bus_req.wdata[9], bus_req.wdata[10]})) else $error("spi2 drive wrong");
	somi_drive_a: assert property (wp |=> drive_low.spi2_somi == $past(bus_req.wdata[11]))
		else $error("somi drive wrong");
	drive_hold_a: assert property (!(ws || wp) |=> $stable(drive_low))
		else $error("drive changed");
	gpb_select_a: assert property (wg |=> gp_port_b_second_select_bit ==
		($past(bus_req.wdata[16]) ? gp_port_b_second_select_bit_alt : gp_port_b_second_select_bit_ded)) else $error("gpb sel");
	gpb_pull_a: assert property (wg && bus_req.wdata[16] |=> (gp_b2_pull == 2'b01) [*2])
		else $error("pull not forced");
	default_path_a: assert property ($fell(sys_rst) |-> timer_channel_input == timer_ded_in
		&& gp_port_b_second_select_bit == gp_port_b_second_select_bit_ded) else $error("not dedicated");
	unmapped_read_a: assert property (bus_req.rd && bus_req.addr == `IMD_PMX_BASE + 32'h8c
		|=> rdata == 32'h0) else $error("unmapped read");
	cover property (wg && bus_req.wdata[16]);
	cover property (wp && bus_req.wdata[11] != bus_req.wdata[24]);
	cover property ($fell(sys_rst));
endmodule
bind imd_input_mux imd_props #(.TMR_CH(TMR_CH)) imd_props_inst (.clk, .sys_rst, .bus_req,
	.rdata, .timer_ded_in, .timer_channel_input, .gp_port_b_second_select_bit_ded, .gp_port_b_second_select_bit_alt,
	.gp_port_b_second_select_bit, .gp_b2_pull, .drive_low);

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`include "imd_cfg.svh"
// ****
// bench
// ****
module tb;
	import imd_pkg::*;
	logic clk = 0, sys_rst = 1, gded = 0, galt = 0, gsel;
	imd_bus_req_t req = '0;
	logic [31:0] rdata, wd;
	logic [31:0] m [38];
	logic [7:0] tded = 0, talt = 0, tsel, et;
	imd_pull_t preq = '0, pull;
	imd_drive_t drv;
	int b1r[8] = `IMD_TMR_B1_REG, b1b[8] = `IMD_TMR_B1_BIT;
	int b2r[8] = `IMD_TMR_B2_REG, b2b[8] = `IMD_TMR_B2_BIT;
	int n_fail = 0, checks_done = 0, seed = 61304, i, c;
	always #12.5 clk = ~clk;
	imd_input_mux imd_input_mux_inst (.clk(clk), .sys_rst(sys_rst), .bus_req(req),
		.rdata(rdata), .timer_ded_in(tded), .timer_alt_in(talt), .timer_channel_input(tsel),
		.gp_port_b_second_select_bit_ded(gded), .gp_port_b_second_select_bit_alt(galt), .gp_port_b_second_select_bit(gsel),
		.gp_b2_pull_req(preq), .gp_b2_pull(pull), .drive_low(drv));
	function logic [31:0] ad(int k);
		return k < 35 ? `IMD_PMX_BASE + 4 * k : k == 35 ? `IMD_SYSTEM_PIN_CONTROL10_ADDR :
			k == 36 ? `IMD_SERIAL_PORT2_PIN_CONTROL9_ADDR : `IMD_PMX_BASE + 32'h8c;
	endfunction
	task chk(string s, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", s, e, g);
			n_fail++;
		end
	endtask
	task wr(int k, logic [31:0] d);
		@(posedge clk) req <= '{ad(k), d, 1'b1, 1'b0};
		@(posedge clk) req.wr <= 0;
		if (k == 36) d[24] = d[11];
		if (k < 37) m[k] = d;
	endtask
	task rd(int k);
		@(posedge clk) req <= '{ad(k), 32'h0, 1'b0, 1'b1};
		@(posedge clk) req.rd <= 0;
		#1 chk("rdata", k < 37 ? m[k] : 32'h0, rdata);
		@(posedge clk) #1 chk("rdata_idle", 32'h0, rdata);
	endtask
	task wrap_up;
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		for (i = 0; i < 38; i++) m[i] = 0;
		repeat (5) @(posedge clk);
		sys_rst <= 0;
		for (i = 0; i < 38; i++) rd(i);
		chk("tsel", tded, tsel);
		for (i = 0; i < 300; i++) begin
			c = {$random(seed)} % 38;
			wd = $random(seed);
			if (c == 9 && m[29][16]) wd = wd & 32'hfffcffff;
			wr(c, wd);
			if (c == 29 && m[29][16]) wr(9, m[9] & 32'hfffcffff);
			rd(c);
			@(posedge clk) {tded, talt, gded, galt, preq} <= 20'($random(seed));
			@(posedge clk);
			#1;
			for (int j = 0; j < 8; j++) et[j] = m[b1r[j]][b1b[j]] & ~m[b2r[j]][b2b[j]] ? talt[j] : tded[j];
			chk("tsel", et, tsel);
			chk("gsel", m[29][16] ? galt : gded, gsel);
			chk("pull", m[29][16] ? 2'b01 : preq, pull);
			chk("drv", {m[35][0], m[36][9], m[36][10], m[36][11]}, drv);
		end
		wrap_up;
	end
endmodule
